// ### hdl/sbm_pkg.sv
// Shared constants, operation codes and helpers of the shift and bit manipulation unit.
package sbm_pkg;

    // Operand width and bit-number field width.
    localparam int DATA_W    = 8;
    localparam int BIT_POS_W = 3;

    // Reset values of the result and flag outputs.
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic       FLAG_RST   = 1'b0;

    // One code per instruction of the shift and bit groups.
    typedef enum logic [4:0] {
        OP_ARITH_SHIFT_LEFT,
        OP_ARITH_SHIFT_RIGHT,
        OP_LOGIC_SHIFT_LEFT,
        OP_LOGIC_SHIFT_RIGHT,
        OP_ROTATE_LEFT_PLAIN,
        OP_ROTATE_RIGHT_PLAIN,
        OP_ROTATE_LEFT_VIA_CARRY,
        OP_ROTATE_RIGHT_VIA_CARRY,
        OP_SINGLE_BIT_SET,
        OP_SINGLE_BIT_CLEAR,
        OP_SINGLE_BIT_INVERT,
        OP_SINGLE_BIT_TEST,
        OP_CARRY_AND_BIT,
        OP_CARRY_AND_INVERTED_BIT,
        OP_CARRY_OR_BIT,
        OP_CARRY_OR_INVERTED_BIT,
        OP_CARRY_XOR_BIT,
        OP_CARRY_XOR_INVERTED_BIT,
        OP_BIT_TO_CARRY,
        OP_INVERTED_BIT_TO_CARRY,
        OP_CARRY_TO_BIT,
        OP_INVERTED_CARRY_TO_BIT
    } sbm_op_type;

    // True for the inverted variants, which only accept an immediate bit number.
    function automatic logic sbm_imm_only(input sbm_op_type op);
        sbm_imm_only = (op == OP_CARRY_AND_INVERTED_BIT) || (op == OP_CARRY_OR_INVERTED_BIT)
                    || (op == OP_CARRY_XOR_INVERTED_BIT) || (op == OP_INVERTED_BIT_TO_CARRY)
                    || (op == OP_INVERTED_CARRY_TO_BIT);
    endfunction : sbm_imm_only

    // True for the shifts and rotates, which only act on a general register.
    function automatic logic sbm_is_shift(input sbm_op_type op);
        sbm_is_shift = (op <= OP_ROTATE_RIGHT_VIA_CARRY);
    endfunction : sbm_is_shift

endpackage : sbm_pkg

// ### hdl/sbm_bit_alu.sv
// Combinational byte datapath: one-bit shifts, rotates and single-bit operations.
module sbm_bit_alu (
    input  wire sbm_pkg::sbm_op_type      op,          // Operation to perform.
    input  wire logic [7:0]               operand,     // Byte from register or memory.
    input  wire logic [2:0]               bit_pos,     // Selected bit number.
    input  wire logic                     carry_in,    // Current carry flag.
    output logic      [7:0]               result,      // Modified byte.
    output logic                          carry_res,   // New carry flag.
    output logic                          zero_res,    // New zero flag.
    output logic                          wr_operand,  // Result must be written back.
    output logic                          wr_carry,    // Carry flag is updated.
    output logic                          wr_zero      // Zero flag is updated.
);

    logic [7:0] bit_mask;
    logic       sel_bit;

    // One-hot mask of the selected bit and the bit itself.
    assign bit_mask = 8'h01 << bit_pos;
    assign sel_bit  = operand[bit_pos];

    // Each shift moves exactly one place; every other bit keeps its value in bit operations.
    always_comb begin
        result     = operand;
        carry_res  = carry_in;
        zero_res   = 1'b0;
        wr_operand = 1'b0;
        wr_carry   = 1'b0;
        wr_zero    = 1'b0;
        unique case (op)
            sbm_pkg::OP_ARITH_SHIFT_LEFT, sbm_pkg::OP_LOGIC_SHIFT_LEFT: begin
                result     = {operand[6:0], 1'b0};
                carry_res  = operand[7];
                wr_operand = 1'b1;
                wr_carry   = 1'b1;
            end
            sbm_pkg::OP_ARITH_SHIFT_RIGHT: begin
                result     = {operand[7], operand[7:1]};
                carry_res  = operand[0];
                wr_operand = 1'b1;
                wr_carry   = 1'b1;
            end
            sbm_pkg::OP_LOGIC_SHIFT_RIGHT: begin
                result     = {1'b0, operand[7:1]};
                carry_res  = operand[0];
                wr_operand = 1'b1;
                wr_carry   = 1'b1;
            end
            sbm_pkg::OP_ROTATE_LEFT_PLAIN: begin
                result     = {operand[6:0], operand[7]};
                carry_res  = operand[7];
                wr_operand = 1'b1;
                wr_carry   = 1'b1;
            end
            sbm_pkg::OP_ROTATE_RIGHT_PLAIN: begin
                result     = {operand[0], operand[7:1]};
                carry_res  = operand[0];
                wr_operand = 1'b1;
                wr_carry   = 1'b1;
            end
            sbm_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
                result     = {operand[6:0], carry_in};
                carry_res  = operand[7];
                wr_operand = 1'b1;
                wr_carry   = 1'b1;
            end
            sbm_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
                result     = {carry_in, operand[7:1]};
                carry_res  = operand[0];
                wr_operand = 1'b1;
                wr_carry   = 1'b1;
            end
            sbm_pkg::OP_SINGLE_BIT_SET: begin
                result     = operand | bit_mask;
                wr_operand = 1'b1;
            end
            sbm_pkg::OP_SINGLE_BIT_CLEAR: begin
                result     = operand & ~bit_mask;
                wr_operand = 1'b1;
            end
            sbm_pkg::OP_SINGLE_BIT_INVERT: begin
                result     = operand ^ bit_mask;
                wr_operand = 1'b1;
            end
            sbm_pkg::OP_SINGLE_BIT_TEST: begin
                zero_res = ~sel_bit;
                wr_zero  = 1'b1;
            end
            sbm_pkg::OP_CARRY_AND_BIT: begin
                carry_res = carry_in & sel_bit;
                wr_carry  = 1'b1;
            end
            sbm_pkg::OP_CARRY_AND_INVERTED_BIT: begin
                carry_res = carry_in & ~sel_bit;
                wr_carry  = 1'b1;
            end
            sbm_pkg::OP_CARRY_OR_BIT: begin
                carry_res = carry_in | sel_bit;
                wr_carry  = 1'b1;
            end
            sbm_pkg::OP_CARRY_OR_INVERTED_BIT: begin
                carry_res = carry_in | ~sel_bit;
                wr_carry  = 1'b1;
            end
            sbm_pkg::OP_CARRY_XOR_BIT: begin
                carry_res = carry_in ^ sel_bit;
                wr_carry  = 1'b1;
            end
            sbm_pkg::OP_CARRY_XOR_INVERTED_BIT: begin
                carry_res = carry_in ^ ~sel_bit;
                wr_carry  = 1'b1;
            end
            sbm_pkg::OP_BIT_TO_CARRY: begin
                carry_res = sel_bit;
                wr_carry  = 1'b1;
            end
            sbm_pkg::OP_INVERTED_BIT_TO_CARRY: begin
                carry_res = ~sel_bit;
                wr_carry  = 1'b1;
            end
            sbm_pkg::OP_CARRY_TO_BIT: begin
                result     = carry_in ? (operand | bit_mask) : (operand & ~bit_mask);
                wr_operand = 1'b1;
            end
            sbm_pkg::OP_INVERTED_CARRY_TO_BIT: begin
                result     = carry_in ? (operand & ~bit_mask) : (operand | bit_mask);
                wr_operand = 1'b1;
            end
            default: begin
                result = operand;
            end
        endcase
    end

endmodule : sbm_bit_alu

// ### hdl/sbm_shift_bit_unit.sv
// Shift, rotate and single-bit execution unit with register and memory operand paths.
//
// Overview of operation
// - Arithmetic shifts move a register byte one place and write it back.
// - Logical shifts move a register byte one place and write it back.
// - Plain rotates feed the bit leaving one end into the other end.
// - Rotates through carry treat the carry flag as a ninth bit.
// - Bit number comes from a 3-bit immediate or low register bits.
// - Bit set forces the selected bit to one, others unchanged.
// - Bit clear forces the selected bit to zero, others unchanged.
// - Bit invert complements the selected bit and writes the byte back.
// - Bit test puts the inverted bit in zero, operand untouched.
// - Carry becomes carry AND selected bit.
// - Carry becomes carry AND inverted selected bit.
// - Carry becomes carry OR selected bit.
// - Carry becomes carry OR inverted selected bit.
// - Carry becomes carry XOR selected bit.
// - Carry becomes carry XOR inverted selected bit.
// - Carry takes the selected bit, operand untouched.
// - Carry takes the inverted selected bit.
// - Selected bit takes the carry, other bits intact.
// - Selected bit takes the inverted carry.
// - Inverted variants take the bit number only from the immediate.
module sbm_shift_bit_unit (
    input  wire logic                 clk,              // Core clock, 50 MHz.
    input  wire logic                 rst_n,            // Synchronous reset, active low.
    input  wire logic                 clk_en,           // Freezes all state while low.
    input  wire logic                 req_valid,        // Instruction offered.
    output logic                      req_ready,        // Unit idle and taking requests.
    input  wire sbm_pkg::sbm_op_type  req_op,           // Operation code.
    input  wire logic                 req_to_mem,       // Operand is a memory byte.
    input  wire logic                 req_bit_from_reg, // Bit number from register low bits.
    input  wire logic [2:0]           req_bit_imm,      // Immediate bit number.
    input  wire logic [7:0]           req_bit_reg,      // Register holding the bit number.
    input  wire logic [7:0]           req_reg_data,     // General register operand.
    input  wire logic                 carry_in,         // Carry flag at issue.
    output logic                      mem_rd_req,       // Memory byte read pending.
    input  wire logic                 mem_rd_valid,     // Read data valid.
    input  wire logic [7:0]           mem_rd_data,      // Memory byte read.
    output logic                      mem_wr_req,       // Memory byte write pending.
    output logic      [7:0]           mem_wr_data,      // Memory byte to write.
    input  wire logic                 mem_wr_done,      // Memory write taken.
    output logic                      done,             // Instruction complete, one cycle.
    output logic      [7:0]           res_data,         // Result byte for the register.
    output logic                      res_reg_we,       // Write result to register, one cycle.
    output logic                      carry_out,        // New carry flag.
    output logic                      carry_we,         // Update carry flag, one cycle.
    output logic                      zero_out,         // New zero flag.
    output logic                      zero_we           // Update zero flag, one cycle.
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } sbm_state_type;

    sbm_state_type       state_reg;
    sbm_state_type       state_next;
    sbm_pkg::sbm_op_type op_reg;
    logic [2:0]          pos_reg;
    logic                carry_reg;
    logic                accept;
    logic                rd_take;
    logic                wr_take;
    logic [2:0]          req_pos;
    sbm_pkg::sbm_op_type alu_op;
    logic [7:0]          alu_operand;
    logic [2:0]          alu_pos;
    logic                alu_carry;
    logic [7:0]          alu_result;
    logic                alu_carry_res;
    logic                alu_zero_res;
    logic                alu_wr_operand;
    logic                alu_wr_carry;
    logic                alu_wr_zero;
    logic                reg_path;
    logic                finish;
    logic                mem_to_write;
    logic                wr_pending_reg;

    // Requests are taken only when idle; shifts never go to memory.
    assign req_ready  = (state_reg == ST_IDLE);
    assign accept     = clk_en && req_valid && req_ready;
    assign reg_path   = !req_to_mem || sbm_pkg::sbm_is_shift(req_op);
    assign rd_take    = clk_en && (state_reg == ST_READ) && mem_rd_valid;
    assign wr_take    = clk_en && (state_reg == ST_WRITE) && mem_wr_done;
    assign mem_rd_req = (state_reg == ST_READ);
    assign mem_wr_req = (state_reg == ST_WRITE);

    // The register form of the bit number is ignored for the inverted variants.
    assign req_pos = (req_bit_from_reg && !sbm_pkg::sbm_imm_only(req_op))
                   ? req_bit_reg[2:0] : req_bit_imm;

    // Register operands go straight through; memory operands use the held command.
    assign alu_op      = (state_reg == ST_IDLE) ? req_op : op_reg;
    assign alu_operand = (state_reg == ST_IDLE) ? req_reg_data : mem_rd_data;
    assign alu_pos     = (state_reg == ST_IDLE) ? req_pos : pos_reg;
    assign alu_carry   = (state_reg == ST_IDLE) ? carry_in : carry_reg;

    sbm_bit_alu u_alu (
        .op         (alu_op),
        .operand    (alu_operand),
        .bit_pos    (alu_pos),
        .carry_in   (alu_carry),
        .result     (alu_result),
        .carry_res  (alu_carry_res),
        .zero_res   (alu_zero_res),
        .wr_operand (alu_wr_operand),
        .wr_carry   (alu_wr_carry),
        .wr_zero    (alu_wr_zero)
    );

    // Flags are committed when the register op is taken or the memory read returns.
    assign finish       = (accept && reg_path) || rd_take;
    assign mem_to_write = rd_take && alu_wr_operand;

    // Command fields are held across the memory wait so the bus may take any time.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_reg    <= sbm_pkg::OP_ARITH_SHIFT_LEFT;
            pos_reg   <= 3'h0;
            carry_reg <= sbm_pkg::FLAG_RST;
        end else if (accept) begin
            op_reg    <= req_op;
            pos_reg   <= req_pos;
            carry_reg <= carry_in;
        end
    end

    // Memory sequence: read the whole byte, modify it, write the whole byte back if the ALU raises wr_operand for the operation.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (accept && !reg_path) begin
                    state_next = ST_READ;
                end
            end
            ST_READ: begin
                if (rd_take) begin
                    state_next = alu_wr_operand ? ST_WRITE : ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (wr_take) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // The written byte is the full read byte with only the selected bit changed.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_wr_data    <= sbm_pkg::RESULT_RST;
            wr_pending_reg <= 1'b0;
        end else if (clk_en) begin
            if (mem_to_write) begin
                mem_wr_data <= alu_result;
            end
            wr_pending_reg <= mem_to_write;
        end
    end

    // Result and flag strobes; a memory op that writes back signals done only after its write is taken.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            res_data   <= sbm_pkg::RESULT_RST;
            res_reg_we <= 1'b0;
            carry_out  <= sbm_pkg::FLAG_RST;
            carry_we   <= 1'b0;
            zero_out   <= sbm_pkg::FLAG_RST;
            zero_we    <= 1'b0;
            done       <= 1'b0;
        end else if (clk_en) begin
            res_reg_we <= 1'b0;
            carry_we   <= 1'b0;
            zero_we    <= 1'b0;
            done       <= wr_take || (finish && !mem_to_write);
            if (finish) begin
                if (accept) begin
                    res_data   <= alu_result;
                    res_reg_we <= alu_wr_operand;
                end
                carry_out <= alu_carry_res;
                carry_we  <= alu_wr_carry;
                zero_out  <= alu_zero_res;
                zero_we   <= alu_wr_zero;
            end
        end
    end

    // Checks below all look one cycle after the triggering edge, which is an enabled edge for every check except a_wr_hold.
    a_ashl_result : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && req_op == sbm_pkg::OP_ARITH_SHIFT_LEFT)
        |=> (res_data == {$past(req_reg_data[6:0]), 1'b0}) && res_reg_we && carry_we
            && (carry_out == $past(req_reg_data[7])))
        else $error("arithmetic shift left result or carry wrong");

    a_ashr_sign : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && req_op == sbm_pkg::OP_ARITH_SHIFT_RIGHT)
        |=> (res_data[7:6] == {2{$past(req_reg_data[7])}}) && (carry_out == $past(req_reg_data[0])))
        else $error("arithmetic shift right lost the sign");

    a_lshr_fill : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && req_op == sbm_pkg::OP_LOGIC_SHIFT_RIGHT)
        |=> (res_data == {1'b0, $past(req_reg_data[7:1])}) && res_reg_we)
        else $error("logical shift right result wrong");

    a_rotate_wrap : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && req_op == sbm_pkg::OP_ROTATE_RIGHT_PLAIN)
        |=> (res_data == {$past(req_reg_data[0]), $past(req_reg_data[7:1])}))
        else $error("plain rotate right did not wrap");

    a_rotc_ninth : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && req_op == sbm_pkg::OP_ROTATE_LEFT_VIA_CARRY)
        |=> (res_data[0] == $past(carry_in)) && (carry_out == $past(req_reg_data[7])))
        else $error("rotate through carry did not use carry");

    a_bit_set : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && reg_path && req_op == sbm_pkg::OP_SINGLE_BIT_SET)
        |=> (res_data == ($past(req_reg_data) | (8'h01 << $past(req_pos)))) && !carry_we)
        else $error("bit set changed the wrong bits");

    a_bit_test : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && reg_path && req_op == sbm_pkg::OP_SINGLE_BIT_TEST)
        |=> zero_we && !res_reg_we && !carry_we && (zero_out == !$past(req_reg_data[req_pos])))
        else $error("bit test zero flag wrong or operand written");

    a_carry_and : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && reg_path && req_op == sbm_pkg::OP_CARRY_AND_BIT)
        |=> carry_we && !res_reg_we && (carry_out == ($past(carry_in) & $past(req_reg_data[req_pos]))))
        else $error("carry and bit result wrong");

    a_inv_imm_only : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && reg_path && req_op == sbm_pkg::OP_INVERTED_BIT_TO_CARRY)
        |=> (carry_out == !$past(req_reg_data[req_bit_imm])))
        else $error("inverted load did not use the immediate bit number");

    a_bit_store : assert property (@(posedge clk) disable iff (!rst_n)
        (accept && reg_path && req_op == sbm_pkg::OP_CARRY_TO_BIT)
        |=> res_reg_we && (res_data == (($past(req_reg_data) & ~(8'h01 << $past(req_pos)))
            | ({7'h00, $past(carry_in)} << $past(req_pos)))))
        else $error("bit store did not place the carry in the selected bit");

    // The write byte must not move while the memory side has not yet taken it.
    a_wr_hold : assert property (@(posedge clk) disable iff (!rst_n)
        (mem_wr_req && !mem_wr_done)
        |=> mem_wr_req && $stable(mem_wr_data))
        else $error("memory write request dropped or data changed before it was taken");

    a_mem_rmw : assert property (@(posedge clk) disable iff (!rst_n)
        (rd_take && op_reg == sbm_pkg::OP_SINGLE_BIT_CLEAR)
        |=> mem_wr_req && (mem_wr_data == ($past(mem_rd_data) & ~(8'h01 << $past(pos_reg))))
            && !done ##0 (wr_pending_reg))
        else $error("memory write back is not the read byte with one bit cleared");

endmodule : sbm_shift_bit_unit

// ### tb/sbm_mem_model.sv
// Behavioural memory byte that answers the unit's read and write requests.
module sbm_mem_model (
    input  wire logic       clk,      // Core clock.
    input  wire logic       rst_n,    // Synchronous reset, active low.
    input  wire logic [1:0] lat,      // Extra wait cycles before each answer.
    input  wire logic       rd_req,   // Read request from the unit.
    output logic            rd_valid, // Read data valid, one cycle.
    output logic      [7:0] rd_data,  // Read byte, scrambled outside valid.
    input  wire logic       wr_req,   // Write request from the unit.
    input  wire logic [7:0] wr_data,  // Byte to store.
    output logic            wr_done   // Write taken, one cycle.
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] mem_byte;
    int         cnt;

    // Answers after a chosen delay; the data lines flip every idle cycle so stale values never look valid.
    always @(posedge clk) begin
        rd_valid <= 1'b0;
        wr_done  <= 1'b0;
        rd_data  <= ~rd_data;
        if (!rst_n) begin
            cnt <= 0;
        end else if ((rd_req && !rd_valid) || (wr_req && !wr_done)) begin
            if (cnt >= int'(lat)) begin
                cnt <= 0;
                if (rd_req) begin
                    rd_valid <= 1'b1;
                    rd_data  <= mem_byte;
                end else begin
                    wr_done  <= 1'b1;
                    mem_byte <= wr_data;
                end
            end else begin
                cnt <= cnt + 1;
            end
        end
    end

endmodule : sbm_mem_model

// ### tb/testbench.sv
// Self-checking bench: every operation on the register path and every bit operation on the memory path against a reference model.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, req_valid = 1'b0, req_ready;
    logic req_to_mem = 1'b0, req_bit_from_reg = 1'b0, carry_in = 1'b0;
    logic [2:0] req_bit_imm = 3'h0;
    logic [7:0] req_bit_reg = 8'h00, req_reg_data = 8'h00, mem_rd_data, mem_wr_data, res_data;
    logic mem_rd_req, mem_rd_valid, mem_wr_req, mem_wr_done, done, res_reg_we;
    logic carry_out, carry_we, zero_out, zero_we;
    logic [1:0] lat = 2'h0;
    sbm_pkg::sbm_op_type req_op = sbm_pkg::OP_ARITH_SHIFT_LEFT;
    int n_fail = 0, comparisons = 0, cyc = 0, seed = 32'hD011;

    sbm_shift_bit_unit i_sbm_shift_bit_unit (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_to_mem(req_to_mem), .req_bit_from_reg(req_bit_from_reg),
        .req_bit_imm(req_bit_imm), .req_bit_reg(req_bit_reg), .req_reg_data(req_reg_data), .carry_in(carry_in),
        .mem_rd_req(mem_rd_req), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .mem_wr_req(mem_wr_req),
        .mem_wr_data(mem_wr_data), .mem_wr_done(mem_wr_done), .done(done), .res_data(res_data),
        .res_reg_we(res_reg_we), .carry_out(carry_out), .carry_we(carry_we), .zero_out(zero_out), .zero_we(zero_we));

    sbm_mem_model i_sbm_mem_model (.clk(clk), .rst_n(rst_n), .lat(lat), .rd_req(mem_rd_req),
        .rd_valid(mem_rd_valid), .rd_data(mem_rd_data), .wr_req(mem_wr_req), .wr_data(mem_wr_data),
        .wr_done(mem_wr_done));

    // Clock of 20 ns period.
    always #10 clk = ~clk;

    // Reference model: returns {write byte, write carry, write zero, carry, zero, byte}.
    function automatic logic [12:0] ref_op(input int op, input logic [7:0] d, input logic [2:0] b, input logic c);
        logic [7:0] r;
        logic       cv;
        r  = d;
        cv = c;
        case (op)
            0, 2: begin r = {d[6:0], 1'b0}; cv = d[7]; end
            1: begin r = {d[7], d[7:1]}; cv = d[0]; end
            3: begin r = {1'b0, d[7:1]}; cv = d[0]; end
            4: begin r = {d[6:0], d[7]}; cv = d[7]; end
            5: begin r = {d[0], d[7:1]}; cv = d[0]; end
            6: begin r = {d[6:0], c}; cv = d[7]; end
            7: begin r = {c, d[7:1]}; cv = d[0]; end
            8: r[b] = 1'b1;
            9: r[b] = 1'b0;
            10: r[b] = ~d[b];
            12: cv = c & d[b];
            13: cv = c & ~d[b];
            14: cv = c | d[b];
            15: cv = c | ~d[b];
            16: cv = c ^ d[b];
            17: cv = c ^ ~d[b];
            18: cv = d[b];
            19: cv = ~d[b];
            20: r[b] = c;
            21: r[b] = ~c;
            default: ;
        endcase
        ref_op = {op <= 10 || op >= 20, op <= 7 || (op >= 12 && op <= 19), op == 11, cv, ~d[b], r};
    endfunction : ref_op

    // Counts one comparison and reports any difference at once.
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic test_done;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // Issues one instruction, waits for completion under a bound and checks every result.
    task automatic run(input int op, input logic mem, input logic fr, input logic [2:0] imm,
                       input logic [7:0] breg, input logic [7:0] d, input logic c);
        logic [12:0] e;
        logic        is_mem;
        int          k;
        is_mem = mem && op >= 8;
        // Inverted variants are the odd codes from 13 to 21 and ignore the register bit number.
        e = ref_op(op, d, (fr && !(op >= 13 && op % 2 == 1)) ? breg[2:0] : imm, c);
        i_sbm_mem_model.mem_byte = d;
        @(posedge clk);
        req_valid <= 1'b1; req_op <= sbm_pkg::sbm_op_type'(op); req_to_mem <= mem; req_bit_from_reg <= fr;
        req_bit_imm <= imm; req_bit_reg <= breg; req_reg_data <= is_mem ? ~d : d; carry_in <= c;
        @(posedge clk);
        req_valid <= 1'b0;
        k = 0;
        @(negedge clk);
        while (done !== 1'b1 && k < 50) begin @(negedge clk); k++; end
        check("done", done, 8'h01);
        check("req_ready", req_ready, 8'h01);
        check("mem_req", {6'h00, mem_rd_req, mem_wr_req}, 8'h00);
        check("res_reg_we", res_reg_we, 8'(!is_mem && e[12]));
        if (!is_mem && e[12]) check("res_data", res_data, e[7:0]);
        check("carry_we", carry_we, 8'(e[11]));
        if (e[11]) check("carry_out", carry_out, 8'(e[9]));
        check("zero_we", zero_we, 8'(e[10]));
        if (e[10]) check("zero_out", zero_out, 8'(e[8]));
        if (is_mem) check("mem_byte", i_sbm_mem_model.mem_byte, e[12] ? e[7:0] : d);
    endtask : run

    // Cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin n_fail++; test_done(); end
    end

    // Main sequence: reset, then every code on the register path and the bit codes 8 to 21 on the memory path, with random operands and latencies.
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset_idle", {5'h00, req_ready, done, mem_rd_req}, 8'h04);
        for (int p = 0; p < 2; p++) begin
            for (int rep = 0; rep < 8; rep++) begin
                for (int o = 0; o < 22; o++) begin
                    lat <= 2'($random(seed));
                    run(o, p[0], 1'($random(seed)), 3'($random(seed)), 8'($random(seed)),
                        8'($random(seed)), 1'($random(seed)));
                end
            end
            $display("test %0s path finished, failures so far %0d", p ? "memory" : "register", n_fail);
        end
        test_done();
    end

endmodule : testbench
